// ### logic/zone_position_reader.sv
// ascii-framed reader answering the zone status and completed position registers
`timescale 1ns/1ns
// How it works
// RULE1: a valid 9013h read returns the live zone status word.
// RULE2: address is axis plus one, 01h..10h; only own address answered and echoed.
// RULE3: zone read query is function 03, start 9013h, count 0001.
// RULE4: position read query is function 03, start 9014h, count 0001.
// RULE5: 9014h reports completed position, or executed program on press variant.
// RULE6: response echoes 03, byte count 02, value as four hex digits msb first.
// RULE7: queries are 17 characters, responses 15 characters overall.
// RULE8: each frame carries a two-character lrc check after the data.
// RULE9: colon header, cr lf trailer, fields in uppercase hex digits.
// RULE10: zone word: zones in bits 0,1, position flag bit 8, limits 12..14.
// RULE11: undefined zone status bits read as zero.
// RULE12: frames with a mismatching check are dropped silently.
module zone_position_reader
	import zone_read_pkg::*;
(
	input  wire logic                          clk,
	input  wire logic                          resetn,
	input  wire logic [3:0]                    axis_number,
	input  wire logic                          press_variant,
	input  wire zone_read_pkg::zone_flags_type zone_flags,
	input  wire logic [15:0]                   completed_position,
	input  wire logic [15:0]                   executed_program,
	input  wire zone_read_pkg::char_type       rx_char,
	output logic                               tx_valid,
	output logic [7:0]                         tx_data,
	input  wire logic                          tx_ready
);
	import zone_read_pkg::*;

	typedef enum logic [1:0] {idle, receive, trailer, transmit} state_type;

	// query bytes: address, function, start pair, count pair, check
	localparam int query_bytes = query_hex_chars / 2;

	// byte index is three bits and the tx counter four, so both layouts are capped
	if (query_bytes > 8 || response_chars > 16 || query_chars != query_hex_chars + 3
		|| response_chars != response_hex_chars + 3)
	begin
		$error("frame layout does not fit the reader counters");
	end

	function automatic logic [4:0] hex_value(input logic [7:0] c);
		if (c >= 8'h30 && c <= 8'h39)
			hex_value = {1'b1, c[3:0]};
		else if (c >= 8'h41 && c <= 8'h46)
			hex_value = {1'b1, c[3:0] + 4'h9};
		else
			hex_value = 5'h00;
	endfunction

	function automatic logic [7:0] hex_char(input logic [3:0] n);
		hex_char = (n < 4'ha) ? {4'h3, n} : {4'h4, n - 4'h9}; // RULE9
	endfunction

	state_type   state_reg, state_next;
	logic [7:0]  bytes_reg [0:query_bytes-1];
	logic [7:0]  bytes_next [0:query_bytes-1];
	logic [3:0]  count_reg, count_next;
	logic [3:0]  nib_reg, nib_next;
	logic        bad_reg, bad_next;
	logic [7:0]  lrc_reg, lrc_next;
	logic [15:0] word_reg, word_next;
	logic [7:0]  tx_data_reg, tx_data_next;
	logic        tx_valid_reg, tx_valid_next;
	logic [15:0] zone_word;
	logic [7:0]  own_addr;
	logic [7:0]  resp_lrc;
	logic [4:0]  hv;
	logic        query_ok;

	always_comb
	begin
		zone_word = '0; // RULE11
		zone_word[zone_one_bit]      = zone_flags.zone_one_flag; // RULE10
		zone_word[zone_two_bit]      = zone_flags.zone_two_flag;
		zone_word[zone_position_bit] = zone_flags.zone_position_flag;
		zone_word[limit_select_bit0] = zone_flags.limit_select_bit_zero;
		zone_word[limit_select_bit1] = zone_flags.limit_select_bit_one;
		zone_word[limit_select_bit2] = zone_flags.limit_select_bit_two;
	end

	assign own_addr = {4'h0, axis_number} + slave_addr_min; // RULE2
	assign hv = hex_value(rx_char.data);
	// bytes 0..5 content, byte 6 received check; sum of all seven is zero when good
	assign query_ok = !bad_reg && count_reg == 4'(query_bytes) && lrc_reg == 8'h00 // RULE8 RULE12
		&& bytes_reg[0] == own_addr && own_addr <= slave_addr_max // RULE2
		&& bytes_reg[1] == func_read_holding // RULE3 RULE4
		&& bytes_reg[2] == addr_zone_status[15:8]
		&& (bytes_reg[3] == addr_zone_status[7:0]
			|| bytes_reg[3] == addr_completed_position[7:0])
		&& {bytes_reg[4], bytes_reg[5]} == reg_count_one;
	assign resp_lrc = 8'h00 - (own_addr + func_read_holding + resp_byte_count
		+ word_reg[15:8] + word_reg[7:0]);

	always_comb
	begin
		state_next    = state_reg;
		count_next    = count_reg;
		nib_next      = nib_reg;
		bad_next      = bad_reg;
		lrc_next      = lrc_reg;
		word_next     = word_reg;
		tx_data_next  = tx_data_reg;
		tx_valid_next = tx_valid_reg;
		for (int i = 0; i < query_bytes; i++)
			bytes_next[i] = bytes_reg[i];
		// a colon restarts framing in every state but transmit, so a torn frame cannot wedge the reader
		if (rx_char.valid && rx_char.data == char_colon && state_reg != transmit)
		begin
			state_next = receive; // RULE9
			count_next = '0;
			nib_next   = '0;
			bad_next   = 1'b0;
			lrc_next   = '0;
		end
		else
		begin
			case (state_reg)
				idle:
					;
				receive:
					if (rx_char.valid)
					begin
						if (rx_char.data == char_cr)
							state_next = (nib_reg == 4'd0) ? trailer : idle;
						else if (!hv[4] || count_reg == 4'(query_bytes))
							bad_next = 1'b1;
						else if (nib_reg == 4'd0)
						begin
							nib_next = {1'b1, hv[2:0]};
							word_next[3:0] = hv[3:0];
						end
						else
						begin
							bytes_next[count_reg[2:0]] = {word_reg[3:0], hv[3:0]};
							lrc_next   = lrc_reg + {word_reg[3:0], hv[3:0]};
							count_next = count_reg + 4'd1;
							nib_next   = '0;
						end
					end
				trailer:
					if (rx_char.valid)
					begin
						state_next = idle;
						if (rx_char.data == char_lf && query_ok) // RULE7
						begin
							state_next = transmit;
							count_next = '0;
							word_next  = (bytes_reg[3] == addr_zone_status[7:0]) ? zone_word // RULE1
								: (press_variant ? executed_program : completed_position); // RULE5
							tx_valid_next = 1'b1;
							tx_data_next  = char_colon;
						end
					end
				transmit:
					if (tx_ready)
					begin
						count_next = count_reg + 4'd1;
						case (count_reg) // RULE6 RULE7
							4'd0:  tx_data_next = hex_char(own_addr[7:4]); // RULE2
							4'd1:  tx_data_next = hex_char(own_addr[3:0]);
							4'd2:  tx_data_next = hex_char(func_read_holding[7:4]);
							4'd3:  tx_data_next = hex_char(func_read_holding[3:0]);
							4'd4:  tx_data_next = hex_char(resp_byte_count[7:4]);
							4'd5:  tx_data_next = hex_char(resp_byte_count[3:0]);
							4'd6:  tx_data_next = hex_char(word_reg[15:12]);
							4'd7:  tx_data_next = hex_char(word_reg[11:8]);
							4'd8:  tx_data_next = hex_char(word_reg[7:4]);
							4'd9:  tx_data_next = hex_char(word_reg[3:0]);
							4'd10: tx_data_next = hex_char(resp_lrc[7:4]); // RULE8
							4'd11: tx_data_next = hex_char(resp_lrc[3:0]);
							4'd12: tx_data_next = char_cr;
							4'd13: tx_data_next = char_lf;
							default:
							begin
								tx_valid_next = 1'b0;
								state_next    = idle;
							end
						endcase
					end
				default:
					state_next = idle;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			state_reg    <= idle;
			count_reg    <= '0;
			nib_reg      <= '0;
			bad_reg      <= 1'b0;
			lrc_reg      <= '0;
			word_reg     <= '0;
			tx_data_reg  <= '0;
			tx_valid_reg <= 1'b0;
			for (int i = 0; i < query_bytes; i++)
				bytes_reg[i] <= '0;
		end
		else
		begin
			state_reg    <= state_next;
			count_reg    <= count_next;
			nib_reg      <= nib_next;
			bad_reg      <= bad_next;
			lrc_reg      <= lrc_next;
			word_reg     <= word_next;
			tx_data_reg  <= tx_data_next;
			tx_valid_reg <= tx_valid_next;
			for (int i = 0; i < query_bytes; i++)
				bytes_reg[i] <= bytes_next[i];
		end
	end

	assign tx_valid = tx_valid_reg;
	assign tx_data  = tx_data_reg;
endmodule

// ### pkg/zone_read_pkg.sv
// constants and carrier types for the ascii zone/position register reader
package zone_read_pkg;
	localparam logic [7:0]  char_colon       = 8'h3a;
	localparam logic [7:0]  char_cr          = 8'h0d;
	localparam logic [7:0]  char_lf          = 8'h0a;
	localparam logic [7:0]  func_read_holding = 8'h03;
	localparam logic [7:0]  resp_byte_count  = 8'h02;
	localparam logic [15:0] addr_zone_status = 16'h9013;
	localparam logic [15:0] addr_completed_position = 16'h9014;
	localparam logic [15:0] reg_count_one    = 16'h0001;
	localparam logic [7:0]  slave_addr_min   = 8'h01;
	localparam logic [7:0]  slave_addr_max   = 8'h10;
	localparam int          query_chars      = 17;
	localparam int          response_chars   = 15;
	localparam int          query_hex_chars  = 14;
	localparam int          response_hex_chars = 12;
	localparam int          zone_one_bit     = 0;
	localparam int          zone_two_bit     = 1;
	localparam int          zone_position_bit = 8;
	localparam int          limit_select_bit0 = 12;
	localparam int          limit_select_bit1 = 13;
	localparam int          limit_select_bit2 = 14;

	typedef struct packed {
		logic zone_one_flag;
		logic zone_two_flag;
		logic zone_position_flag;
		logic limit_select_bit_zero;
		logic limit_select_bit_one;
		logic limit_select_bit_two;
	} zone_flags_type;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} char_type;
endpackage

// ### bench/zone_position_reader_chk.sv
// assertions on the response stream of the zone/position reader
`timescale 1ns/1ns
module zone_position_reader_chk
(
	input wire logic                    clk,
	input wire logic                    resetn,
	input wire logic [3:0]              axis_number,
	input wire zone_read_pkg::char_type rx_char,
	input wire logic                    tx_valid,
	input wire logic [7:0]              tx_data,
	input wire logic                    tx_ready
);
	import zone_read_pkg::*;
	logic [3:0] sent_reg;
	logic [3:0] sent_next;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// chars already taken in the current response
	always_comb
		sent_next = (!resetn || !tx_valid) ? 4'h0 : sent_reg + {3'h0, tx_ready};
	always_ff @(posedge clk)
		sent_reg <= sent_next;
	a_reset_quiet: assert property (disable iff (1'b0) !resetn |=> !tx_valid)
		else $error("busy in reset");
	a_header_first: assert property ($rose(tx_valid) |-> tx_data == char_colon)
		else $error("no header");
	a_after_lf: assert property ($rose(tx_valid) |-> $past(rx_char.valid && rx_char.data == char_lf))
		else $error("early reply");
	a_char_held: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("char dropped");
	a_hex_upper: assert property (tx_valid && sent_reg inside {[1:12]} |->
		tx_data inside {[8'h30:8'h39], [8'h41:8'h46]})
		else $error("bad digit");
	a_func_echo: assert property (tx_valid && sent_reg == 4'h4 |-> tx_data == 8'h33)
		else $error("bad function");
	a_count_echo: assert property (tx_valid && sent_reg == 4'h6 |-> tx_data == 8'h32)
		else $error("bad byte count");
	a_lf_last: assert property (tx_valid && tx_ready && sent_reg == 4'he |->
		tx_data == char_lf ##1 !tx_valid)
		else $error("bad length");
	// only axis fifteen gives address 10h, so the high digit is 1 there alone
	a_addr_high: assert property (tx_valid && sent_reg == 4'h1 |->
		tx_data == ((axis_number == 4'hf) ? 8'h31 : 8'h30))
		else $error("bad address digit");
	a_trailer_cr: assert property (tx_valid && sent_reg == 4'hd |-> tx_data == char_cr)
		else $error("no trailer");
endmodule
bind zone_position_reader zone_position_reader_chk chk (.clk, .resetn, .axis_number, .rx_char,
	.tx_valid, .tx_data, .tx_ready);

// ### bench/modbus_master_model.sv
// ascii master model: sends queries and takes response chars
`timescale 1ns/1ns
module modbus_master_model
(
	input  wire logic               clk,
	input  wire logic               slow,
	output zone_read_pkg::char_type rx_char,
	input  wire logic               tx_valid,
	input  wire logic [7:0]         tx_data,
	output logic                    tx_ready
);
	import zone_read_pkg::*;
	logic [7:0] got[$];
	logic [3:0] tick = 4'h0;
	initial rx_char = '0;
	// a slow consumer stalls half the cycles
	assign tx_ready = !slow || tick[1];
	always @(posedge clk)
	begin
		tick <= tick + 4'h1;
		if (tx_valid && tx_ready)
			got.push_back(tx_data);
	end
	function automatic logic [7:0] hx(input logic [3:0] n);
		return n < 4'ha ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
	endfunction
	task automatic put(input logic [7:0] c);
		@(posedge clk);
		rx_char <= '{1'b1, c};
	endtask
	// lx nonzero corrupts the check
	task automatic send(input logic [7:0] ad, input logic [15:0] st, input logic [7:0] lx);
		logic [47:0] b;
		logic [7:0]  l;
		b = {ad, func_read_holding, st, reg_count_one};
		l = (8'h00 - (b[47:40] + b[39:32] + b[31:24] + b[23:16] + b[15:8] + b[7:0])) ^ lx;
		got.delete();
		put(char_colon);
		for (int i = 11; i >= 0; i--)
			put(hx(b[i * 4 +: 4]));
		put(hx(l[7:4]));
		put(hx(l[3:0]));
		put(char_cr);
		put(char_lf);
		@(posedge clk);
		rx_char <= '{1'b0, ~char_lf};
	endtask
	// raw chars for refused and torn frames; close adds the cr lf trailer
	task automatic send_raw(input string s, input logic close);
		got.delete();
		for (int i = 0; i < s.len(); i++)
			put(s[i]);
		if (close)
		begin
			put(char_cr);
			put(char_lf);
		end
		@(posedge clk);
		rx_char <= '{1'b0, ~char_lf};
	endtask
endmodule

// ### bench/tb_zone_position_reader.sv
// self-checking bench for the zone/position reader
`timescale 1ns/1ns
module tb_zone_position_reader;
	import zone_read_pkg::*;
	typedef struct packed {logic [3:0] ax; logic pr; logic sl;
		logic [15:0] st; logic [5:0] zf; logic [15:0] w;} row_type;
	row_type rows[7] = '{'{4'h0, 1'b0, 1'b0, 16'h9013, 6'h00, 16'h0000},
		'{4'h0, 1'b0, 1'b1, 16'h9013, 6'h30, 16'h0003},
		'{4'hf, 1'b0, 1'b0, 16'h9013, 6'h08, 16'h0100},
		'{4'h3, 1'b1, 1'b1, 16'h9013, 6'h07, 16'h7000},
		'{4'h0, 1'b0, 1'b0, 16'h9014, 6'h3f, 16'h0003},
		'{4'h7, 1'b1, 1'b1, 16'h9014, 6'h3f, 16'h01c5},
		'{4'ha, 1'b0, 1'b0, 16'h9013, 6'h24, 16'h1001}};
	logic           clk = 1'b0;
	logic           resetn = 1'b0;
	logic [3:0]     axis_number = 4'h0;
	logic           press_variant = 1'b0;
	zone_flags_type zone_flags = '0;
	logic           slow = 1'b0;
	logic [15:0]    completed_position = 16'h0003;
	logic [15:0]    executed_program = 16'h01c5;
	// own address 0B: wrong start, function, count, lower case, odd and long digit runs
	string          refused[6] = '{":0B03901500014C", ":0B04901300014D",
		":0B03901300024D", ":0b03901300014E", ":0B03901300014", ":0B03901300014E0"};
	char_type       rx_char;
	logic           tx_valid;
	logic [7:0]     tx_data;
	logic           tx_ready;
	int             n_fail = 0;
	int             check_count = 0;
	always #4 clk = ~clk;
	modbus_master_model m (.clk, .slow, .rx_char, .tx_valid, .tx_data, .tx_ready);
	zone_position_reader dut (.clk, .resetn, .axis_number, .press_variant, .zone_flags,
		.completed_position, .executed_program, .rx_char, .tx_valid,
		.tx_data, .tx_ready);
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		check_count++;
		if (seen !== want)
		begin
			n_fail++;
			$display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic frame(input logic [7:0] ad, input logic [15:0] w);
		logic [39:0] b;
		logic [7:0]  l;
		logic [7:0]  e[15];
		b = {ad, func_read_holding, resp_byte_count, w};
		l = 8'h00 - (b[39:32] + b[31:24] + b[23:16] + b[15:8] + b[7:0]);
		e[0] = char_colon;
		for (int k = 0; k < 10; k++)
			e[k + 1] = m.hx(b[(9 - k) * 4 +: 4]);
		e[11] = m.hx(l[7:4]);
		e[12] = m.hx(l[3:0]);
		e[13] = char_cr;
		e[14] = char_lf;
		for (int t = 0; t < 400 && m.got.size() < 15; t++)
			@(posedge clk);
		check(8'(m.got.size()), 8'h0f);
		for (int k = 0; k < 15; k++)
			check(m.got[k], e[k]);
	endtask
	initial
	begin
		repeat (4) @(posedge clk);
		check({7'h0, tx_valid}, 8'h00);
		resetn <= 1'b1;
		for (int i = 0; i < $size(rows); i++)
		begin
			axis_number <= rows[i].ax;
			press_variant <= rows[i].pr;
			zone_flags <= rows[i].zf;
			slow <= rows[i].sl;
			m.send({4'h0, rows[i].ax} + 8'h01, rows[i].st, 8'h00);
			frame({4'h0, rows[i].ax} + 8'h01, rows[i].w);
		end
		m.send(8'h0b, addr_zone_status, 8'h01);
		repeat (40) @(posedge clk);
		check(8'(m.got.size()), 8'h00);
		m.send(8'h05, addr_zone_status, 8'h00);
		repeat (40) @(posedge clk);
		check(8'(m.got.size()), 8'h00);
		foreach (refused[j])
		begin
			m.send_raw(refused[j], 1'b1);
			repeat (40) @(posedge clk);
			check(8'(m.got.size()), 8'h00);
		end
		// a colon in mid-query restarts framing
		m.send_raw(":0B0390", 1'b0);
		m.send(8'h0b, addr_zone_status, 8'h00);
		frame(8'h0b, 16'h1001);
		// the second query lands while the first is answered and must be ignored
		completed_position <= 16'h03e8;
		m.send(8'h0b, addr_completed_position, 8'h00);
		m.send(8'h0b, addr_completed_position, 8'h00);
		frame(8'h0b, 16'h03e8);
		repeat (40) @(posedge clk);
		check(8'(m.got.size()), 8'h0f);
		// reset in mid-response stops the stream; the next query gets a full answer
		m.send(8'h0b, addr_zone_status, 8'h00);
		repeat (5) @(posedge clk);
		check({7'h0, tx_valid}, 8'h01);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		check({7'h0, tx_valid}, 8'h00);
		resetn <= 1'b1;
		m.send(8'h0b, addr_zone_status, 8'h00);
		frame(8'h0b, 16'h1001);
		wrap_up();
	end
	initial
	begin
		#20000;
		n_fail++;
		wrap_up();
	end
endmodule
